// [mdp_bbp_model.sv]
/* Baseband partner model for the modem data port.
   Assumes the bench fills rx_q and reads tx_q by hierarchical reference. */
`timescale 1ns/1ps
module mdp_bbp_model (
    input  wire logic demod_enable_out,
    input  wire logic transmit_request_out,
    input  wire logic tx_data_out,
    input  wire logic cca_level,
    output logic      rx_bit_clock,
    output logic      rx_data_in,
    output logic      demod_valid_in,
    output logic      tx_bit_clock,
    output logic      transmit_go_in,
    output logic      cca_in
);
    logic rx_q[$];
    logic tx_q[$];
    int   abort_at = -1;
    int   n;
    bit   more;
    bit   first;
    assign cca_in = cca_level;
    ////////////////////////////////////////////////////////////////////////////
    // The receive clock stands still outside frames and released data toggles.
    always
    begin
        rx_bit_clock = 1'b0;
        demod_valid_in = 1'b0;
        rx_data_in = (rx_data_in !== 1'b1);
        wait (demod_enable_out);
        #1207;
        more = rx_q.size() > 0;
        if (more)
        begin
            demod_valid_in = 1'b1;
            rx_data_in = rx_q.pop_front();
            #960;
            n = 0;
        end
        while (demod_enable_out && more)
        begin
            rx_bit_clock = 1'b1;
            #80;
            more = rx_q.size() > 0;
            rx_data_in = more ? rx_q.pop_front() : ~rx_data_in;
            n++;
            if (n == abort_at)
                demod_valid_in = 1'b0;
            #80;
            rx_bit_clock = 1'b0;
            #160;
        end
        wait (!demod_enable_out);
        rx_q.delete();
    end
    ////////////////////////////////////////////////////////////////////////////
    always
    begin
        tx_bit_clock = 1'b0;
        transmit_go_in = 1'b0;
        wait (transmit_request_out);
        #2007;
        transmit_go_in = 1'b1;
        #300;
        first = 1'b1;
        while (transmit_request_out)
        begin
            tx_bit_clock = 1'b1;
            if (!first)
                tx_q.push_back(tx_data_out);
            first = 1'b0;
            #160;
            tx_bit_clock = 1'b0;
            #160;
        end
        #1000;
        transmit_go_in = 1'b0;
    end
endmodule : mdp_bbp_model

// [mdp_crc.sv]
/*
 * Serial LSB-first HEC (CRC16) and FCS (CRC32) engine.
 * Assumes one bit per step pulse from the owner.
 */
`timescale 1ns/1ps
module mdp_crc
    import mdp_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_b,
    mdp_crc_if.eng    crc
);
    logic [15:0] next_hec;
    logic [31:0] next_fcs;
    logic [15:0] hec_q;
    logic [31:0] fcs_q;

    always_comb
    begin
        next_hec = hec_q;
        next_fcs = fcs_q;
        if (crc.init)
        begin
            next_hec = HEC_INIT;
            next_fcs = FCS_INIT;
        end
        else if (crc.step)
        begin
            next_hec = (hec_q >> 1) ^ ((hec_q[0] ^ crc.bit_in) ? HEC_POLY_REV : 16'h0000);
            next_fcs = (fcs_q >> 1) ^ ((fcs_q[0] ^ crc.bit_in) ? FCS_POLY_REV : 32'h00000000);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            hec_q <= HEC_INIT;
            fcs_q <= FCS_INIT;
        end
        else
        begin
            hec_q <= next_hec;
            fcs_q <= next_fcs;
        end
    end

    assign crc.hec = hec_q;
    assign crc.fcs = fcs_q;
endmodule : mdp_crc

// [mdp_crc_if.sv]
/*
 * Carrier between the top module and its CRC engine.
 * Assumes both ends run on mclk.
 */
`timescale 1ns/1ps
interface mdp_crc_if;
    logic        init;
    logic        step;
    logic        bit_in;
    logic [15:0] hec;
    logic [31:0] fcs;
    modport ctl (output init, output step, output bit_in, input hec, input fcs);
    modport eng (input init, input step, input bit_in, output hec, output fcs);
endinterface : mdp_crc_if

// [mdp_pkg.sv]
/*
 * Constants and types shared by the modem data port.
 * Assumes a 25 MHz master clock; bit clocks come from the baseband.
 */
package mdp_pkg;

    localparam int          MCLK_MHZ        = 25;
    localparam int          WORD_W          = 16;
    localparam int          BIT_CNT_W       = 4;
    localparam int          PE_IDLE_MCLK    = 3;
    localparam logic [1:0]  PE_IDLE_CNT     = 2'(PE_IDLE_MCLK);
    localparam int          CCA_WINDOW_US   = 10;
    localparam int          CCA_WINDOW_CNT  = CCA_WINDOW_US * MCLK_MHZ;
    localparam int          CCA_CNT_W       = 9;
    localparam int          HDR_BITS        = 48;
    localparam logic [5:0]  HDR_BITS_M1     = 6'(HDR_BITS - 1);
    localparam logic [15:0] HEC_INIT        = 16'hffff;
    localparam logic [15:0] HEC_POLY_REV    = 16'h8408;
    localparam logic [31:0] FCS_INIT        = 32'hffffffff;
    localparam logic [31:0] FCS_POLY_REV    = 32'hedb88320;
    localparam logic [31:0] FCS_RESIDUE     = 32'hdebb20e3;
    localparam logic [15:0] HEC_RESIDUE     = 16'hf0b8;

    typedef enum logic [2:0] {
        MDP_IDLE,
        MDP_RX_GAP,
        MDP_RX_ON,
        MDP_TX_WAIT_GO,
        MDP_TX_DATA,
        MDP_TX_DRAIN
    } mdp_state_type;

endpackage : mdp_pkg

// [mdp_port.sv]
/*
 * Modem data port, MAC side: receive deserialiser, transmit serialiser, checks, keystream mixing.
 * Assumes the controller services each word in real time and supplies the WEP keystream.
 */
// How it works
// - Receive bits deserialised into words, resynchronised.
// - HEC and FCS checked on receive.
// - Receive data after the header XORed with keystream when enabled.
// - Transmit words serialised on transmit clock.
// - Only FCS appended to transmit, not HEC.
// - Transmit data XORed with keystream when enabled.
// - One word at a time, no FIFO.
// - Transmission refused while last channel sample busy.
// - Only MPDU bits are sent.
// - Header fields taken from live stream.
// - Demodulator enable starts and stops search.
// - Device ends reception by dropping enable.
// - Enable held low at least three clocks.
// - Channel sampled within ten microseconds of enable.
// - Request, wait for go, then send bits.
// - Drop request after last bit, await go low.
// - Request returns low before each packet.
// - Bits sent LSB first on rising edge.
`timescale 1ns/1ps
module mdp_port
    import mdp_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              rx_start,
    input  wire logic              rx_stop,
    input  wire logic              tx_start,
    input  wire logic              wep_enable,
    input  wire logic [WORD_W-1:0] wep_key_word,
    input  wire logic [WORD_W-1:0] tx_word,
    input  wire logic              tx_word_valid,
    input  wire logic              tx_last,
    input  wire logic              rx_bit_clock,
    input  wire logic              rx_data_in,
    input  wire logic              demod_valid_in,
    input  wire logic              tx_bit_clock,
    input  wire logic              transmit_go_in,
    input  wire logic              cca_in,
    output logic                   demod_enable_out,
    output logic                   transmit_request_out,
    output logic                   tx_data_out,
    output logic [WORD_W-1:0]      rx_word,
    output logic                   rx_word_done,
    output logic                   rx_header_done,
    output logic                   rx_hec_ok,
    output logic                   rx_fcs_ok,
    output logic                   rx_abort,
    output logic                   tx_word_done,
    output logic                   tx_busy_flag,
    output logic                   cca_busy,
    output logic                   tx_done
);
    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers. The baseband clocks are slow against mclk, so edge
    // detection on the second stage suffices.
    logic [1:0] rxc_s, txc_s, rxd_s, rdy_s, go_s, cca_s;
    logic       rxc_d, txc_d;
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            rxc_s <= 2'h0; txc_s <= 2'h0; rxd_s <= 2'h0;
            rdy_s <= 2'h0; go_s  <= 2'h0; cca_s <= 2'h0;
            rxc_d <= 1'b0; txc_d <= 1'b0;
        end
        else
        begin
            rxc_s <= {rxc_s[0], rx_bit_clock};
            txc_s <= {txc_s[0], tx_bit_clock};
            rxd_s <= {rxd_s[0], rx_data_in};
            rdy_s <= {rdy_s[0], demod_valid_in};
            go_s  <= {go_s[0], transmit_go_in};
            cca_s <= {cca_s[0], cca_in};
            rxc_d <= rxc_s[1];
            txc_d <= txc_s[1];
        end
    end
    // Data changes two mclk after the rising edge, so the synchronised copy
    // is still stable when the synchronised edge is seen.
    wire rx_rise = rxc_s[1] & ~rxc_d;
    wire tx_rise = txc_s[1] & ~txc_d;
    wire rx_bit  = rxd_s[1];
    wire rdy     = rdy_s[1];
    wire go      = go_s[1];

    ////////////////////////////////////////////////////////////////////////////
    // Control state.
    mdp_state_type              state, next_state;
    logic [1:0]                 gap, next_gap;
    logic [CCA_CNT_W-1:0]       ccnt, next_ccnt;
    logic [BIT_CNT_W-1:0]       bcnt, next_bcnt;
    logic [5:0]                 hcnt, next_hcnt;
    logic                       in_hdr, next_in_hdr, was_rdy, next_was_rdy;
    logic [WORD_W-1:0]          sh, next_sh, txw, next_txw;
    logic                       txw_full, next_txw_full, last_q, next_last_q;
    logic [5:0]                 fcs_left, next_fcs_left;
    logic [31:0]                fcs_hold, next_fcs_hold;
    logic                       next_en, next_req, next_txd;
    logic [WORD_W-1:0]          next_rx_word;
    logic                       next_rwd, next_hdone, next_hok, next_fok, next_abort;
    logic                       next_twd, next_busy, next_ccab, next_done;
    logic [WORD_W-1:0]          key_mask;
    logic [15:0]                hec_step;
    logic [31:0]                fcs_step;

    mdp_crc_if crc ();
    mdp_crc u_crc (.mclk(mclk), .rst_b(rst_b), .crc(crc));

    assign key_mask = wep_enable ? wep_key_word : '0;
    // Check values one step ahead, so the bit being shifted this cycle is included.
    assign hec_step = (crc.hec >> 1) ^ ((crc.hec[0] ^ rx_bit) ? HEC_POLY_REV : 16'h0000);
    assign fcs_step = (crc.fcs >> 1) ^ ((crc.fcs[0] ^ txw[bcnt]) ? FCS_POLY_REV : 32'h00000000);

    always_comb
    begin
        next_state = state; next_gap = gap; next_ccnt = ccnt; next_bcnt = bcnt;
        next_hcnt = hcnt; next_in_hdr = in_hdr; next_was_rdy = rdy; next_sh = sh;
        next_txw = txw; next_txw_full = txw_full; next_last_q = last_q;
        next_fcs_left = fcs_left; next_fcs_hold = fcs_hold;
        next_en = demod_enable_out; next_req = transmit_request_out; next_txd = tx_data_out;
        next_rx_word = rx_word; next_rwd = 1'b0; next_hdone = 1'b0; next_abort = 1'b0;
        next_hok = rx_hec_ok; next_fok = rx_fcs_ok; next_twd = 1'b0; next_done = 1'b0;
        next_busy = 1'b0; next_ccab = cca_busy;
        crc.init = 1'b0; crc.step = 1'b0; crc.bit_in = 1'b0;
        case (state)
            MDP_IDLE:
            begin
                next_en = 1'b0;
                next_req = 1'b0;
                if (tx_start && tx_word_valid)
                begin
                    if (!cca_busy)
                    begin
                        next_txw = tx_word ^ key_mask;
                        next_txw_full = 1'b1;
                        next_last_q = tx_last;
                        next_twd = 1'b1;
                        next_req = 1'b1;
                        next_bcnt = '0;
                        next_fcs_left = '0;
                        crc.init = 1'b1;
                        next_state = MDP_TX_WAIT_GO;
                    end
                    else
                        next_busy = 1'b1;
                end
                else if (rx_start)
                begin
                    next_gap = '0;
                    next_state = MDP_RX_GAP;
                end
            end
            MDP_RX_GAP:
            begin
                next_gap = gap + 2'h1;
                if (gap == PE_IDLE_CNT - 2'h1)
                begin
                    next_en = 1'b1;
                    next_ccnt = '0;
                    next_in_hdr = 1'b0; next_hcnt = '0; next_bcnt = '0;
                    next_state = MDP_RX_ON;
                end
            end
            MDP_RX_ON:
            begin
                if (ccnt != CCA_CNT_W'(CCA_WINDOW_CNT))
                begin
                    next_ccnt = ccnt + 1'b1;
                    if (ccnt == CCA_CNT_W'(CCA_WINDOW_CNT - 1))
                        next_ccab = ~cca_s[1];
                end
                if (!rdy && was_rdy)
                    next_abort = 1'b1;
                if (rdy && !was_rdy)
                begin
                    next_in_hdr = 1'b1;
                    next_hcnt = '0; next_bcnt = '0;
                    crc.init = 1'b1;
                end
                else if (rdy && rx_rise)
                begin
                    crc.step = 1'b1;
                    crc.bit_in = rx_bit;
                    next_sh = {rx_bit, sh[WORD_W-1:1]};
                    next_bcnt = bcnt + 1'b1;
                    if (bcnt == BIT_CNT_W'(WORD_W - 1))
                    begin
                        next_rx_word = next_sh ^ (in_hdr ? '0 : key_mask);
                        next_rwd = 1'b1;
                    end
                    if (in_hdr)
                    begin
                        next_hcnt = hcnt + 6'h1;
                        if (hcnt == HDR_BITS_M1)
                        begin
                            next_in_hdr = 1'b0;
                            next_hdone = 1'b1;
                            next_hok = (hec_step == HEC_RESIDUE);
                            next_bcnt = '0;
                            crc.init = 1'b1;
                            crc.step = 1'b0;
                        end
                    end
                end
                next_fok = (crc.fcs == FCS_RESIDUE);
                if (rx_stop)
                begin
                    next_en = 1'b0;
                    next_state = MDP_IDLE;
                end
            end
            MDP_TX_WAIT_GO:
                if (go)
                    next_state = MDP_TX_DATA;
            MDP_TX_DATA:
            begin
                if (!txw_full && fcs_left == 6'h0 && tx_word_valid && !last_q)
                begin
                    next_txw = tx_word ^ key_mask;
                    next_txw_full = 1'b1;
                    next_last_q = tx_last;
                    next_twd = 1'b1;
                end
                if (tx_rise)
                begin
                    // The baseband takes each bit on the following rise, so the
                    // request stays up for one rise past the final check bit.
                    if (fcs_left > 6'h1)
                    begin
                        next_txd = fcs_hold[0];
                        next_fcs_hold = fcs_hold >> 1;
                        next_fcs_left = fcs_left - 6'h1;
                    end
                    else if (fcs_left == 6'h1)
                    begin
                        next_fcs_left = 6'h0;
                        next_req = 1'b0;
                        next_state = MDP_TX_DRAIN;
                    end
                    else if (txw_full)
                    begin
                        next_txd = txw[bcnt];
                        crc.step = 1'b1;
                        crc.bit_in = txw[bcnt];
                        next_bcnt = bcnt + 1'b1;
                        if (bcnt == BIT_CNT_W'(WORD_W - 1))
                        begin
                            next_txw_full = 1'b0;
                            if (last_q)
                            begin
                                next_fcs_left = 6'h21;
                                next_fcs_hold = ~fcs_step;
                            end
                        end
                    end
                end
            end
            MDP_TX_DRAIN:
                if (!go)
                begin
                    next_done = 1'b1;
                    next_state = MDP_IDLE;
                end
            default:
                next_state = MDP_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state <= MDP_IDLE; gap <= '0; ccnt <= '0; bcnt <= '0; hcnt <= '0;
            in_hdr <= 1'b0; was_rdy <= 1'b0; sh <= '0; txw <= '0; txw_full <= 1'b0;
            last_q <= 1'b0; fcs_left <= '0; fcs_hold <= '0;
            demod_enable_out <= 1'b0; transmit_request_out <= 1'b0; tx_data_out <= 1'b0;
            rx_word <= '0; rx_word_done <= 1'b0; rx_header_done <= 1'b0; rx_hec_ok <= 1'b0;
            rx_fcs_ok <= 1'b0; rx_abort <= 1'b0; tx_word_done <= 1'b0; tx_busy_flag <= 1'b0;
            cca_busy <= 1'b0; tx_done <= 1'b0;
        end
        else
        begin
            state <= next_state; gap <= next_gap; ccnt <= next_ccnt; bcnt <= next_bcnt;
            hcnt <= next_hcnt; in_hdr <= next_in_hdr; was_rdy <= next_was_rdy; sh <= next_sh;
            txw <= next_txw; txw_full <= next_txw_full; last_q <= next_last_q;
            fcs_left <= next_fcs_left; fcs_hold <= next_fcs_hold;
            demod_enable_out <= next_en; transmit_request_out <= next_req; tx_data_out <= next_txd;
            rx_word <= next_rx_word; rx_word_done <= next_rwd; rx_header_done <= next_hdone;
            rx_hec_ok <= next_hok; rx_fcs_ok <= next_fok; rx_abort <= next_abort;
            tx_word_done <= next_twd; tx_busy_flag <= next_busy; cca_busy <= next_ccab;
            tx_done <= next_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_gap;
        @(posedge mclk) disable iff (!rst_b)
        $rose(demod_enable_out) |-> $past(demod_enable_out, 2) == 1'b0 && $past(demod_enable_out, 3) == 1'b0;
    endproperty
    a_gap: assert property (p_gap) else $error("enable low too briefly");
    property p_req_busy;
        @(posedge mclk) disable iff (!rst_b)
        $rose(transmit_request_out) |-> !$past(cca_busy);
    endproperty
    a_req_busy: assert property (p_req_busy) else $error("transmit on busy channel");
    property p_no_overlap;
        @(posedge mclk) disable iff (!rst_b)
        !(demod_enable_out && transmit_request_out);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("rx and tx both on");
    property p_stop;
        @(posedge mclk) disable iff (!rst_b)
        (rx_stop && state == MDP_RX_ON) |=> !demod_enable_out;
    endproperty
    a_stop: assert property (p_stop) else $error("enable not dropped");
    property p_done;
        @(posedge mclk) disable iff (!rst_b)
        tx_done |-> !transmit_request_out && !$past(go);
    endproperty
    a_done: assert property (p_done) else $error("done before go low");
    property p_abort;
        @(posedge mclk) disable iff (!rst_b)
        (state == MDP_RX_ON && $past(state) == MDP_RX_ON && was_rdy && !rdy) |=> rx_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("abort missed");
    property p_rwd;
        @(posedge mclk) disable iff (!rst_b)
        rx_word_done |-> $past(rx_rise);
    endproperty
    a_rwd: assert property (p_rwd) else $error("word done without bit");
    property p_tx_shift;
        @(posedge mclk) disable iff (!rst_b)
        $changed(tx_data_out) |-> $past(tx_rise);
    endproperty
    a_tx_shift: assert property (p_tx_shift) else $error("tx bit moved off edge");
    c_rx: cover property (@(posedge mclk) rx_word_done);
    c_tx: cover property (@(posedge mclk) tx_done);
    c_abort: cover property (@(posedge mclk) rx_abort);
endmodule : mdp_port

// [tb_top.sv]
/* Self-checking bench for the modem data port.
   Assumes the baseband model answers on the far side. */
`timescale 1ns/1ps
module tb_top
    import mdp_pkg::*;
;
    logic mclk = 0, rst_b = 0, rx_start = 0, rx_stop = 0, tx_start = 0, wep_enable = 0;
    logic tx_word_valid = 0, tx_last = 0, cca_level = 1;
    logic [15:0] wep_key_word = 0, tx_word = 0, rx_word;
    logic rx_bit_clock, rx_data_in, demod_valid_in, tx_bit_clock, transmit_go_in, cca_in;
    logic demod_enable_out, transmit_request_out, tx_data_out, rx_word_done, rx_header_done;
    logic rx_hec_ok, rx_fcs_ok, rx_abort, tx_word_done, tx_busy_flag, cca_busy, tx_done;
    logic [15:0] rx_got[$], exp_q[$], w[3];
    logic        exp_tx[$];
    logic [31:0] c;
    int fail_count = 0, tests_run = 0, hdr_n = 0, abort_n = 0, busy_n = 0, done_n = 0, i, n;
    always #20 mclk = ~mclk;
    mdp_port DUT (.mclk(mclk), .rst_b(rst_b), .rx_start(rx_start), .rx_stop(rx_stop),
        .tx_start(tx_start), .wep_enable(wep_enable), .wep_key_word(wep_key_word), .tx_word(tx_word),
        .tx_word_valid(tx_word_valid), .tx_last(tx_last), .rx_bit_clock(rx_bit_clock),
        .rx_data_in(rx_data_in), .demod_valid_in(demod_valid_in), .tx_bit_clock(tx_bit_clock),
        .transmit_go_in(transmit_go_in), .cca_in(cca_in), .demod_enable_out(demod_enable_out),
        .transmit_request_out(transmit_request_out), .tx_data_out(tx_data_out), .rx_word(rx_word),
        .rx_word_done(rx_word_done), .rx_header_done(rx_header_done), .rx_hec_ok(rx_hec_ok),
        .rx_fcs_ok(rx_fcs_ok), .rx_abort(rx_abort), .tx_word_done(tx_word_done),
        .tx_busy_flag(tx_busy_flag), .cca_busy(cca_busy), .tx_done(tx_done));
    mdp_bbp_model u_bbp (.demod_enable_out(demod_enable_out), .transmit_request_out(transmit_request_out),
        .tx_data_out(tx_data_out), .cca_level(cca_level), .rx_bit_clock(rx_bit_clock),
        .rx_data_in(rx_data_in), .demod_valid_in(demod_valid_in), .tx_bit_clock(tx_bit_clock),
        .transmit_go_in(transmit_go_in), .cca_in(cca_in));
    always @(posedge mclk)
    begin
        if (rx_word_done === 1'b1)
            rx_got.push_back(rx_word);
        hdr_n += int'(rx_header_done === 1'b1);
        abort_n += int'(rx_abort === 1'b1);
        busy_n += int'(tx_busy_flag === 1'b1);
        done_n += int'(tx_done === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic final_report;
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // Reflected serial CRC step; the 16-bit check keeps its upper half at zero.
    function automatic logic [31:0] crc_upd(input logic [31:0] s, input logic b, input logic [31:0] p);
        return (s[0] ^ b) ? ((s >> 1) ^ p) : (s >> 1);
    endfunction : crc_upd
    // Seven words: two header, HEC, two payload, FCS low and high halves.
    task automatic rx_frame(input int abort_at);
        logic [15:0] v;
        logic [31:0] f;
        exp_q.delete();
        rx_got.delete();
        u_bbp.abort_at = abort_at;
        c = 32'(HEC_INIT);
        for (int k = 0; k < 7; k++)
        begin
            v = 16'($urandom());
            f = ~c;
            if (k == 2 || k == 5)
                v = f[15:0];
            if (k == 6)
                v = f[31:16];
            if (k == 3)
                c = FCS_INIT;
            for (int b = 0; b < 16; b++)
            begin
                u_bbp.rx_q.push_back(v[b]);
                if (k != 2 && k < 5)
                    c = crc_upd(c, v[b], (k < 2) ? 32'(HEC_POLY_REV) : FCS_POLY_REV);
            end
            exp_q.push_back((k >= 3 && wep_enable) ? (v ^ wep_key_word) : v);
        end
    endtask : rx_frame
    task automatic pulse_rx(input bit stop);
        rx_start <= !stop;
        rx_stop <= stop;
        @(posedge mclk);
        rx_start <= 1'b0;
        rx_stop <= 1'b0;
    endtask : pulse_rx
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h36ea));
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        #1 check({demod_enable_out, transmit_request_out, rx_abort, tx_done}, 0);
        @(posedge mclk);
        wep_enable <= 1'($urandom());
        wep_key_word <= 16'($urandom());
        @(posedge mclk);
        rx_frame(-1);
        pulse_rx(0);
        repeat (4) @(posedge mclk);
        #1 check(demod_enable_out, 1);
        wait (rx_got.size() == 7);
        repeat (8) @(posedge mclk);
        check(rx_hec_ok, 1);
        check(rx_fcs_ok, 1);
        check(hdr_n, 1);
        for (i = 0; i < 7; i++)
            check(rx_got[i], exp_q[i]);
        // Immediate restart after stop, on a busy channel.
        cca_level <= 1'b0;
        pulse_rx(1);
        pulse_rx(0);
        n = 0;
        repeat (20) @(posedge mclk) n += int'(demod_enable_out !== 1'b1);
        check(32'(n >= 3), 1);
        repeat (300) @(posedge mclk);
        check(cca_busy, 1);
        pulse_rx(1);
        tx_start <= 1'b1;
        tx_word_valid <= 1'b1;
        @(posedge mclk);
        tx_start <= 1'b0;
        tx_word_valid <= 1'b0;
        repeat (6) @(posedge mclk);
        check(busy_n, 1);
        check(transmit_request_out, 0);
        // Aborted reception mid-header on a clear channel.
        cca_level <= 1'b1;
        rx_frame(20);
        pulse_rx(0);
        repeat (400) @(posedge mclk);
        check(abort_n, 1);
        check(hdr_n, 1);
        pulse_rx(1);
        // Transmission of three words, FCS appended.
        c = FCS_INIT;
        exp_tx.delete();
        for (i = 0; i < 3; i++)
        begin
            w[i] = 16'($urandom());
            for (n = 0; n < 16; n++)
            begin
                exp_tx.push_back(w[i][n] ^ (wep_enable & wep_key_word[n]));
                c = crc_upd(c, exp_tx[$], FCS_POLY_REV);
            end
        end
        for (n = 0; n < 32; n++)
            exp_tx.push_back(~c[n]);
        repeat (4) @(posedge mclk);
        tx_word <= w[0];
        tx_word_valid <= 1'b1;
        tx_start <= 1'b1;
        @(posedge mclk);
        tx_start <= 1'b0;
        tx_word <= w[1];
        @(posedge mclk);
        #1 check(transmit_request_out, 1);
        i = 1;
        while (i < 3)
        begin
            @(posedge mclk);
            if (tx_word_done === 1'b1)
            begin
                i++;
                tx_word <= w[i % 3];
                tx_last <= (i == 2);
                tx_word_valid <= (i < 3);
            end
        end
        wait (done_n == 1);
        check(transmit_go_in, 0);
        check(transmit_request_out, 0);
        check(u_bbp.tx_q.size(), 80);
        for (i = 0; i < 80; i++)
            check(u_bbp.tx_q[i], exp_tx[i]);
        final_report();
    end
    // About 100 us of traffic is expected; the limit leaves wide margin.
    initial
    begin
        #400000;
        fail_count++;
        final_report();
    end
endmodule : tb_top
